//--- design/ssbt_combine.sv
// combines a bus and a digital select code by the chosen source option
`timescale 1ns/100ps
`default_nettype none

module ssbt_combine (
    ssbt_sel_if.combiner sel
);

    always_comb begin
        case (sel.src)
            ssbt_pkg::SSBT_SRC_DIG: sel.result = sel.dig_code;
            ssbt_pkg::SSBT_SRC_SER: sel.result = sel.bus_code;
            ssbt_pkg::SSBT_SRC_AND: sel.result = sel.bus_code & sel.dig_code;
            ssbt_pkg::SSBT_SRC_OR: sel.result = sel.bus_code | sel.dig_code;
            default: sel.result = sel.dig_code;
        endcase
    end

endmodule

`default_nettype wire

//--- design/ssbt_top.sv
// setup source selection, serial jog and telegram timeout supervision
//
// What this block does
// - two-bit code picks setup 1 to 4, msb high bit, 00 is setup 1.
// - setup source is digital, serial, bitwise AND or bitwise OR.
// - AND option forms each select bit as bus bit AND digital bit.
// - OR option forms each select bit as bus bit OR digital bit.
// - serial preset references count only while profile is native.
// - two serial jog speeds, 0 up to high limit, default 10.0 Hz.
// - serial jog selection works only while profile code is 0.
// - telegram gap limit 1 to 99 seconds, default 1 second.
// - gap over limit means link lost; apply chosen timeout reaction.
// - reactions: 0 off, 1 freeze, 2 stop, 3 jog, 4 max, 5 stop+trip.
// - any reaction 1 to 5 on timeout drops the output relay.
// - freeze present, stop, hold jog, hold max frequency, or stop and trip.
`timescale 1ns/100ps
`default_nettype none
`include "ssbt_cfg.svh"

module ssbt_top #(
    parameter int unsigned TICK_CYCLES = `SSBT_TICK_CYCLES
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic [1:0] dig_setup_pin,
    input wire logic [1:0] dig_preset_pin,
    input wire logic tel_valid,
    input wire logic [1:0] tel_setup,
    input wire logic [1:0] tel_preset,
    input wire logic tel_jog_a,
    input wire logic tel_jog_b,
    input wire logic [15:0] freq_now,
    input wire logic [15:0] jog_freq,
    output logic [1:0] active_setup,
    output logic [1:0] preset_sel,
    output logic jog_cmd_en,
    output logic [15:0] jog_speed,
    output logic comm_lost,
    output logic relay_on,
    output logic freq_hold_en,
    output logic [15:0] freq_hold,
    output logic stop_cmd,
    output logic trip
);

    localparam logic [26:0] TICK_LAST = 27'(TICK_CYCLES - 1);

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    logic [3:0] meta_reg, sync_reg;
    logic wr_pend_reg, wr_pend_next;
    logic [7:0] wr_addr_reg, wr_addr_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] setup_src_reg, setup_src_next;
    logic [1:0] preset_src_reg, preset_src_next;
    logic [1:0] profile_reg, profile_next;
    logic [2:0] tofn_reg, tofn_next;
    logic [6:0] limit_reg, limit_next;
    logic [15:0] jog_a_reg, jog_a_next;
    logic [15:0] jog_b_reg, jog_b_next;
    logic [15:0] fmax_reg, fmax_next;
    logic [26:0] tick_cnt_reg, tick_cnt_next;
    logic [6:0] sec_reg, sec_next;
    logic lost_reg, lost_next;
    logic trip_reg, trip_next;
    logic [15:0] freeze_reg, freeze_next;
    logic [1:0] setup_out_reg, setup_out_next;
    logic [1:0] preset_out_reg, preset_out_next;
    logic jog_en_reg, jog_en_next;
    logic [15:0] jog_spd_reg, jog_spd_next;
    logic relay_reg, relay_next;
    logic hold_en_reg, hold_en_next;
    logic [15:0] hold_reg, hold_next;
    logic stop_reg, stop_next;
    logic tick, trip_clr, addr_ok;
    logic [31:0] wd;

    ssbt_sel_if setup_if ();
    ssbt_sel_if preset_if ();

    ssbt_combine u_setup_comb (.sel(setup_if.combiner));
    ssbt_combine u_preset_comb (.sel(preset_if.combiner));

    // ------------------------------------------------------------------------
    // select sources
    // ------------------------------------------------------------------------
    assign setup_if.src = ssbt_pkg::ssbt_src_t'(setup_src_reg);
    assign setup_if.bus_code = tel_setup;
    assign setup_if.dig_code = sync_reg[1:0];
    // bus preset bits only honoured under the native profile
    assign preset_if.src = (profile_reg == ssbt_pkg::SSBT_PROF_NATIVE) ?
        ssbt_pkg::ssbt_src_t'(preset_src_reg) : ssbt_pkg::SSBT_SRC_DIG;
    assign preset_if.bus_code = tel_preset;
    assign preset_if.dig_code = sync_reg[3:2];

    // ------------------------------------------------------------------------
    // bus slave and registers
    // ------------------------------------------------------------------------
    assign addr_ok = hsel && htrans[1] && hready;
    assign wd = hwdata;

    always_comb begin
        wr_pend_next = addr_ok && hwrite;
        wr_addr_next = haddr[7:0];
        setup_src_next = setup_src_reg;
        preset_src_next = preset_src_reg;
        profile_next = profile_reg;
        tofn_next = tofn_reg;
        limit_next = limit_reg;
        jog_a_next = jog_a_reg;
        jog_b_next = jog_b_reg;
        fmax_next = fmax_reg;
        trip_clr = 1'b0;
        if (wr_pend_reg) begin
            case (wr_addr_reg)
                `SSBT_OFF_CTRL: begin
                    setup_src_next = wd[`SSBT_CTRL_SETUP_LSB +: 2];
                    preset_src_next = wd[`SSBT_CTRL_PRESET_LSB +: 2];
                    // codes above fast I/O are ignored
                    if (wd[`SSBT_CTRL_PROFILE_LSB +: 2] <= ssbt_pkg::SSBT_PROF_FAST_IO) begin
                        profile_next = wd[`SSBT_CTRL_PROFILE_LSB +: 2];
                    end
                    // codes above 5 are ignored
                    if (wd[`SSBT_CTRL_TOFN_LSB +: 3] <= ssbt_pkg::SSBT_TO_STOP_TRIP) begin
                        tofn_next = wd[`SSBT_CTRL_TOFN_LSB +: 3];
                    end
                end
                `SSBT_OFF_LIMIT: begin
                    // clamp to 1..99 seconds
                    if (wd[31:0] < 32'(`SSBT_LIMIT_MIN)) begin
                        limit_next = `SSBT_LIMIT_MIN;
                    end else if (wd[31:0] > 32'(`SSBT_LIMIT_MAX)) begin
                        limit_next = `SSBT_LIMIT_MAX;
                    end else begin
                        limit_next = wd[6:0];
                    end
                end
                // jog speeds clamp to the high limit
                `SSBT_OFF_JOG_A: jog_a_next = (wd[15:0] > fmax_reg) ? fmax_reg : wd[15:0];
                `SSBT_OFF_JOG_B: jog_b_next = (wd[15:0] > fmax_reg) ? fmax_reg : wd[15:0];
                `SSBT_OFF_FMAX: fmax_next = wd[15:0];
                `SSBT_OFF_CLEAR: trip_clr = wd[`SSBT_CLEAR_TRIP_BIT];
                default: ;
            endcase
        end
        // reads see this cycle's write so back-to-back access stays coherent
        rdata_next = rdata_reg;
        if (addr_ok && !hwrite) begin
            case (haddr[7:0])
                `SSBT_OFF_CTRL: rdata_next = {21'h0, tofn_next, 2'h0, profile_next,
                    preset_src_next, setup_src_next};
                `SSBT_OFF_LIMIT: rdata_next = {25'h0, limit_next};
                `SSBT_OFF_JOG_A: rdata_next = {16'h0, jog_a_next};
                `SSBT_OFF_JOG_B: rdata_next = {16'h0, jog_b_next};
                `SSBT_OFF_FMAX: rdata_next = {16'h0, fmax_next};
                `SSBT_OFF_STATUS: rdata_next = {24'h0, jog_en_reg, trip_reg, relay_reg,
                    lost_reg, preset_out_reg, setup_out_reg};
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            rdata_reg <= 32'h0000_0000;
            setup_src_reg <= `SSBT_RST_SETUP_SRC;
            preset_src_reg <= `SSBT_RST_PRESET_SRC;
            profile_reg <= `SSBT_RST_PROFILE;
            tofn_reg <= `SSBT_RST_TOFN;
            limit_reg <= `SSBT_RST_LIMIT;
            jog_a_reg <= `SSBT_RST_JOG;
            jog_b_reg <= `SSBT_RST_JOG;
            fmax_reg <= `SSBT_RST_FMAX;
        end else begin
            wr_pend_reg <= wr_pend_next;
            wr_addr_reg <= wr_addr_next;
            rdata_reg <= rdata_next;
            setup_src_reg <= setup_src_next;
            preset_src_reg <= preset_src_next;
            profile_reg <= profile_next;
            tofn_reg <= tofn_next;
            limit_reg <= limit_next;
            jog_a_reg <= jog_a_next;
            jog_b_reg <= jog_b_next;
            fmax_reg <= fmax_next;
        end
    end

    // ------------------------------------------------------------------------
    // gap timer and timeout reaction
    // ------------------------------------------------------------------------
    assign tick = (tick_cnt_reg == TICK_LAST);

    always_comb begin
        // telegram restarts the second count from zero
        tick_cnt_next = (tel_valid || tick) ? 27'h000_0000 : tick_cnt_reg + 27'h000_0001;
        sec_next = sec_reg;
        lost_next = lost_reg;
        if (tel_valid) begin
            sec_next = 7'h00;
            lost_next = 1'b0;
        end else if (tick) begin
            if (sec_reg != 7'h7F) begin
                sec_next = sec_reg + 7'h01;
            end
            // limit seconds without telegram means link lost
            if ({1'b0, sec_reg} + 8'h01 >= {1'b0, limit_reg}) begin
                lost_next = 1'b1;
            end
        end
        // capture the output frequency as the link drops
        freeze_next = (lost_next && !lost_reg) ? freq_now : freeze_reg;
        // set wins over software clear
        trip_next = trip_reg;
        if (trip_clr) begin
            trip_next = 1'b0;
        end
        if (lost_reg && tofn_reg == ssbt_pkg::SSBT_TO_STOP_TRIP) begin
            trip_next = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            tick_cnt_reg <= 27'h000_0000;
            sec_reg <= 7'h00;
            lost_reg <= 1'b0;
            trip_reg <= 1'b0;
            freeze_reg <= 16'h0000;
        end else begin
            tick_cnt_reg <= tick_cnt_next;
            sec_reg <= sec_next;
            lost_reg <= lost_next;
            trip_reg <= trip_next;
            freeze_reg <= freeze_next;
        end
    end

    // ------------------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------------------
    always_comb begin
        setup_out_next = setup_if.result;
        preset_out_next = preset_if.result;
        jog_en_next = jog_en_reg;
        jog_spd_next = jog_spd_reg;
        if (profile_reg != ssbt_pkg::SSBT_PROF_ALT) begin
            jog_en_next = 1'b0;
        end else if (tel_valid) begin
            jog_en_next = tel_jog_a || tel_jog_b;
            jog_spd_next = tel_jog_b ? jog_b_reg : jog_a_reg;
        end
        relay_next = !(lost_reg && tofn_reg != ssbt_pkg::SSBT_TO_OFF);
        hold_en_next = 1'b0;
        hold_next = hold_reg;
        stop_next = 1'b0;
        if (lost_reg) begin
            case (tofn_reg)
                ssbt_pkg::SSBT_TO_FREEZE: begin
                    hold_en_next = 1'b1;
                    hold_next = freeze_reg;
                end
                ssbt_pkg::SSBT_TO_JOG: begin
                    hold_en_next = 1'b1;
                    hold_next = jog_freq;
                end
                ssbt_pkg::SSBT_TO_MAX: begin
                    hold_en_next = 1'b1;
                    hold_next = fmax_reg;
                end
                ssbt_pkg::SSBT_TO_STOP, ssbt_pkg::SSBT_TO_STOP_TRIP: stop_next = 1'b1;
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            meta_reg <= 4'h0;
            sync_reg <= 4'h0;
            setup_out_reg <= 2'h0;
            preset_out_reg <= 2'h0;
            jog_en_reg <= 1'b0;
            jog_spd_reg <= 16'h0000;
            relay_reg <= 1'b1;
            hold_en_reg <= 1'b0;
            hold_reg <= 16'h0000;
            stop_reg <= 1'b0;
        end else begin
            meta_reg <= {dig_preset_pin, dig_setup_pin};
            sync_reg <= meta_reg;
            setup_out_reg <= setup_out_next;
            preset_out_reg <= preset_out_next;
            jog_en_reg <= jog_en_next;
            jog_spd_reg <= jog_spd_next;
            relay_reg <= relay_next;
            hold_en_reg <= hold_en_next;
            hold_reg <= hold_next;
            stop_reg <= stop_next;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_reg;
    assign active_setup = setup_out_reg;
    assign preset_sel = preset_out_reg;
    assign jog_cmd_en = jog_en_reg;
    assign jog_speed = jog_spd_reg;
    assign comm_lost = lost_reg;
    assign relay_on = relay_reg;
    assign freq_hold_en = hold_en_reg;
    assign freq_hold = hold_reg;
    assign stop_cmd = stop_reg;
    assign trip = trip_reg;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence s_quiet_tick;
        tick && !tel_valid && ({1'b0, sec_reg} + 8'h01 >= {1'b0, limit_reg});
    endsequence

    chk_and_combine: assert property (
        setup_src_reg == ssbt_pkg::SSBT_SRC_AND |=> active_setup == ($past(tel_setup) & $past(sync_reg[1:0])))
        else $error("and combination wrong");
    chk_or_combine: assert property (
        setup_src_reg == ssbt_pkg::SSBT_SRC_OR |=> active_setup == ($past(tel_setup) | $past(sync_reg[1:0])))
        else $error("or combination wrong");
    chk_serial_only: assert property (
        setup_src_reg == ssbt_pkg::SSBT_SRC_SER |=> active_setup == $past(tel_setup))
        else $error("serial source wrong");
    chk_preset_mask: assert property (
        profile_reg != ssbt_pkg::SSBT_PROF_NATIVE |=> preset_sel == $past(sync_reg[3:2]))
        else $error("bus preset used outside native profile");
    chk_limit_range: assert property (
        limit_reg >= `SSBT_LIMIT_MIN && limit_reg <= `SSBT_LIMIT_MAX)
        else $error("limit out of range");
    chk_timeout_fires: assert property (
        s_quiet_tick |=> comm_lost ##1 (relay_on || tofn_reg == ssbt_pkg::SSBT_TO_OFF ||
        $past(tofn_reg) != tofn_reg) == (tofn_reg == ssbt_pkg::SSBT_TO_OFF || $changed(tofn_reg)))
        else $error("timeout not raised");
    chk_tel_restart: assert property (
        tel_valid |=> sec_reg == 7'h00 && !comm_lost && tick_cnt_reg == 27'h000_0000)
        else $error("telegram did not restart timer");
    chk_relay_drop: assert property (
        lost_reg && tofn_reg != ssbt_pkg::SSBT_TO_OFF && $stable(tofn_reg) |=> !relay_on)
        else $error("relay not dropped");
    chk_jog_profile: assert property (
        jog_cmd_en |-> $past(profile_reg) == ssbt_pkg::SSBT_PROF_ALT)
        else $error("jog outside profile 0");
    chk_trip_hold: assert property (
        trip && !trip_clr |=> trip)
        else $error("trip lost without clear");

endmodule

`default_nettype wire

//--- inc/ssbt_cfg.svh
// offsets, field positions, reset values and timing counts of the setup source block
`ifndef SSBT_CFG_SVH
`define SSBT_CFG_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define SSBT_OFF_CTRL 8'h00
`define SSBT_OFF_LIMIT 8'h04
`define SSBT_OFF_JOG_A 8'h08
`define SSBT_OFF_JOG_B 8'h0C
`define SSBT_OFF_FMAX 8'h10
`define SSBT_OFF_STATUS 8'h14
`define SSBT_OFF_CLEAR 8'h18

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define SSBT_CTRL_SETUP_LSB 0
`define SSBT_CTRL_PRESET_LSB 2
`define SSBT_CTRL_PROFILE_LSB 4
`define SSBT_CTRL_TOFN_LSB 8
`define SSBT_CLEAR_TRIP_BIT 0

// ----------------------------------------------------------------------------
// reset values and limit clamp bounds
// ----------------------------------------------------------------------------
`define SSBT_RST_SETUP_SRC 2'h3
`define SSBT_RST_PRESET_SRC 2'h3
`define SSBT_RST_PROFILE 2'h1
`define SSBT_RST_TOFN 3'h0
`define SSBT_RST_LIMIT 7'h01
`define SSBT_LIMIT_MIN 7'h01
`define SSBT_LIMIT_MAX 7'h63
`define SSBT_RST_JOG 16'h0064
`define SSBT_RST_FMAX 16'h01F4

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define SSBT_CLK_HZ 100_000_000
`define SSBT_TICK_S 1
`define SSBT_TICK_CYCLES (`SSBT_TICK_S * `SSBT_CLK_HZ)

`endif

//--- inc/ssbt_pkg.sv
// types shared by the setup source block
package ssbt_pkg;

    typedef logic [1:0] ssbt_code_t;

    typedef enum logic [1:0] {
        SSBT_SRC_DIG = 2'h0,
        SSBT_SRC_SER = 2'h1,
        SSBT_SRC_AND = 2'h2,
        SSBT_SRC_OR = 2'h3
    } ssbt_src_t;

    typedef enum logic [1:0] {
        SSBT_PROF_ALT = 2'h0,
        SSBT_PROF_NATIVE = 2'h1,
        SSBT_PROF_FAST_IO = 2'h2
    } ssbt_prof_t;

    typedef enum logic [2:0] {
        SSBT_TO_OFF = 3'h0,
        SSBT_TO_FREEZE = 3'h1,
        SSBT_TO_STOP = 3'h2,
        SSBT_TO_JOG = 3'h3,
        SSBT_TO_MAX = 3'h4,
        SSBT_TO_STOP_TRIP = 3'h5
    } ssbt_tofn_t;

endpackage

//--- inc/ssbt_sel_if.sv
// carrier between the top and a select-code combiner
`timescale 1ns/100ps
`default_nettype none

interface ssbt_sel_if;
    ssbt_pkg::ssbt_src_t src;
    ssbt_pkg::ssbt_code_t bus_code;
    ssbt_pkg::ssbt_code_t dig_code;
    ssbt_pkg::ssbt_code_t result;

    modport combiner (
        input src,
        input bus_code,
        input dig_code,
        output result
    );

    modport user (
        output src,
        output bus_code,
        output dig_code,
        input result
    );
endinterface

`default_nettype wire

//--- verification/ssbt_tel_master.sv
// fieldbus master model that sends control telegrams
`timescale 1ns/100ps
`default_nettype none

module ssbt_tel_master (
    input wire logic sys_clk,
    output logic tel_valid,
    output logic [1:0] tel_setup,
    output logic [1:0] tel_preset,
    output logic tel_jog_a,
    output logic tel_jog_b
);
    initial begin
        tel_valid = 1'b0;
        tel_setup = 2'h0;
        tel_preset = 2'h0;
        tel_jog_a = 1'b0;
        tel_jog_b = 1'b0;
    end

    // one telegram: fields stay as levels, valid is a one-cycle pulse
    task automatic send(input logic [1:0] s, input logic [1:0] p, input logic a,
            input logic b);
        tel_setup <= s;
        tel_preset <= p;
        tel_jog_a <= a;
        tel_jog_b <= b;
        tel_valid <= 1'b1;
        @(posedge sys_clk);
        tel_valid <= 1'b0;
        @(posedge sys_clk);
    endtask
endmodule

`default_nettype wire

//--- verification/testbench.sv
// self-checking bench for the setup source block
`timescale 1ns/100ps
`default_nettype none

module testbench;
    logic sys_clk, reset, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0] htrans, dig_setup_pin, dig_preset_pin, active_setup, preset_sel;
    logic [2:0] hsize;
    logic tel_valid, tel_jog_a, tel_jog_b, jog_cmd_en, comm_lost, relay_on;
    logic freq_hold_en, stop_cmd, trip;
    logic [1:0] tel_setup, tel_preset;
    logic [15:0] freq_now, jog_freq, jog_speed, freq_hold;
    int num_errors = 0;
    int comparisons = 0;

    ssbt_top #(.TICK_CYCLES(20)) DUT (.sys_clk(sys_clk), .reset(reset), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .dig_setup_pin(dig_setup_pin), .dig_preset_pin(dig_preset_pin),
        .tel_valid(tel_valid), .tel_setup(tel_setup), .tel_preset(tel_preset),
        .tel_jog_a(tel_jog_a), .tel_jog_b(tel_jog_b), .freq_now(freq_now),
        .jog_freq(jog_freq), .active_setup(active_setup), .preset_sel(preset_sel),
        .jog_cmd_en(jog_cmd_en), .jog_speed(jog_speed), .comm_lost(comm_lost),
        .relay_on(relay_on), .freq_hold_en(freq_hold_en), .freq_hold(freq_hold),
        .stop_cmd(stop_cmd), .trip(trip));

    ssbt_tel_master master (.sys_clk(sys_clk), .tel_valid(tel_valid),
        .tel_setup(tel_setup), .tel_preset(tel_preset), .tel_jog_a(tel_jog_a),
        .tel_jog_b(tel_jog_b));

    // ------------------------------------------------------------------------
    // clock and watchdog
    // ------------------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        test_done();
    end

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    task automatic test_done();
        if (num_errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // single word transfer, waits on hready in both phases
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
            output logic [31:0] r);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        hsel <= 1'b1;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        r = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0000_0000, q);
        chk(q, exp);
        chk(hresp, 1'b0);
    endtask

    function automatic logic [1:0] comb(input int src, input logic [1:0] b,
            input logic [1:0] d);
        case (src)
            0: comb = d;
            1: comb = b;
            2: comb = b & d;
            default: comb = b | d;
        endcase
    endfunction

    // ------------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------------
    initial begin
        reset = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        dig_setup_pin = 2'h0;
        dig_preset_pin = 2'h0;
        freq_now = 16'h0123;
        jog_freq = 16'h0045;
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        rd_chk(32'h0000_0000, 32'h0000_001F);
        rd_chk(32'h0000_0004, 32'h0000_0001);
        rd_chk(32'h0000_0008, 32'h0000_0064);
        rd_chk(32'h0000_000C, 32'h0000_0064);
        rd_chk(32'h0000_001C, 32'h0000_0000);
        wr(32'h0000_0004, 32'h0000_0000);
        rd_chk(32'h0000_0004, 32'h0000_0001);
        wr(32'h0000_0004, 32'h0000_0064);
        rd_chk(32'h0000_0004, 32'h0000_0063);
        // every source option against every bus and pin code
        for (int s = 0; s < 4; s++) begin
            wr(32'h0000_0000, 32'h0000_001C | s);
            for (int b = 0; b < 4; b++) begin
                for (int d = 0; d < 4; d++) begin
                    dig_setup_pin <= d[1:0];
                    master.send(b[1:0], 2'h0, 1'b0, 1'b0);
                    repeat (4) @(posedge sys_clk);
                    chk(active_setup, comb(s, b[1:0], d[1:0]));
                end
            end
        end
        // jog and preset gating by profile
        wr(32'h0000_0000, 32'h0000_000F);
        wr(32'h0000_0008, 32'h0000_0050);
        wr(32'h0000_000C, 32'h0000_0300);
        rd_chk(32'h0000_000C, 32'h0000_01F4);
        dig_preset_pin <= 2'h2;
        master.send(2'h0, 2'h1, 1'b1, 1'b0);
        repeat (4) @(posedge sys_clk);
        chk(jog_cmd_en, 1'b1);
        chk(jog_speed, 16'h0050);
        chk(preset_sel, 2'h2);
        master.send(2'h0, 2'h1, 1'b1, 1'b1);
        repeat (2) @(posedge sys_clk);
        chk(jog_speed, 16'h01F4);
        master.send(2'h0, 2'h1, 1'b0, 1'b0);
        wr(32'h0000_0000, 32'h0000_001F);
        master.send(2'h0, 2'h1, 1'b0, 1'b1);
        repeat (4) @(posedge sys_clk);
        chk(jog_cmd_en, 1'b0);
        chk(preset_sel, 2'h3);
        // fast I/O profile accepted, code 3 refused
        wr(32'h0000_0000, 32'h0000_002F);
        wr(32'h0000_0000, 32'h0000_003F);
        rd_chk(32'h0000_0000, 32'h0000_002F);
        master.send(2'h0, 2'h1, 1'b1, 1'b0);
        repeat (4) @(posedge sys_clk);
        chk(preset_sel, 2'h2);
        chk(jog_cmd_en, 1'b0);
        // timeout reactions, limit two seconds of twenty cycles
        wr(32'h0000_0004, 32'h0000_0002);
        for (int f = 0; f < 6; f++) begin
            wr(32'h0000_0000, 32'h0000_001F | (f << 8));
            master.send(2'h0, 2'h0, 1'b0, 1'b0);
            repeat (35) @(posedge sys_clk);
            chk(comm_lost, 1'b0);
            repeat (10) @(posedge sys_clk);
            chk(comm_lost, 1'b1);
            chk(relay_on, f == 0);
            chk(stop_cmd, f == 2 || f == 5);
            chk(trip, f == 5);
            chk(freq_hold_en, f == 1 || f == 3 || f == 4);
            if (f == 1) chk(freq_hold, 16'h0123);
            if (f == 3) chk(freq_hold, 16'h0045);
            if (f == 4) chk(freq_hold, 16'h01F4);
            master.send(2'h0, 2'h0, 1'b0, 1'b0);
            @(posedge sys_clk);
            chk(comm_lost, 1'b0);
            wr(32'h0000_0018, 32'h0000_0001);
            rd_chk(32'h0000_0014, 32'h0000_002B);
        end
        test_done();
    end
endmodule

`default_nettype wire
